// >>> inc/bfl_pkg.sv
// Shared constants and types for the bit, flag, load and store datapath.
// Assumes a single 100 MHz clock domain and a 16-entry working register file.
`default_nettype none
package bfl_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int IDX_W = 4;
	// Status register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] PTR_STEP = 16'h0001;
	// Pointer pairs inside the working register file (low byte index)
	localparam logic [3:0] IDX_XL = 4'hA;
	localparam logic [3:0] IDX_YL = 4'hC;
	localparam logic [3:0] IDX_ZL = 4'hE;
	// Register port map
	localparam logic [4:0] REGA_WORK_LAST = 5'h0F;
	localparam logic [4:0] REGA_STATUS = 5'h10;
	localparam logic [4:0] REGA_BUSY = 5'h11;
	typedef enum logic [4:0] {
		OP_NONE = 5'h00, OP_LOGIC_SHIFT_LEFT = 5'h01,
		OP_LOGIC_SHIFT_RIGHT = 5'h02, OP_ROTATE_LEFT_CARRY = 5'h03,
		OP_ROTATE_RIGHT_CARRY = 5'h04, OP_ARITH_RIGHT_SHIFT = 5'h05,
		OP_NIBBLE_SWAP = 5'h06, OP_STATUS_BIT_RAISE = 5'h07,
		OP_STATUS_BIT_LOWER = 5'h08, OP_IO_BIT_RAISE = 5'h09,
		OP_IO_BIT_LOWER = 5'h0A, OP_REG_BIT_TO_TFLAG = 5'h0B,
		OP_TFLAG_TO_REG_BIT = 5'h0C, OP_REGISTER_COPY = 5'h0D,
		OP_IMMEDIATE_LOAD = 5'h0E, OP_MEMORY_READ_INDIRECT = 5'h0F,
		OP_MEMORY_READ_DIRECT = 5'h10, OP_MEMORY_WRITE_INDIRECT = 5'h11
	} bfl_op_t;
	typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} bfl_ptr_t;
	typedef enum logic [1:0] {
		AM_PLAIN = 2'h0, AM_POST_INC = 2'h1, AM_PRE_DEC = 2'h2
	} bfl_mode_t;
endpackage
`default_nettype wire

// >>> inc/bfl_dp_if.sv
// Links the execution core to its register file and shift unit.
// Assumes all three modules share one clock.
`default_nettype none
interface bfl_dp_if;
	import bfl_pkg::*;
	logic [3:0] rdAddrA, rdAddrB, rdAddrC;
	logic [7:0] rdDataA, rdDataB, rdDataC;
	logic [15:0] ptrX, ptrY, ptrZ;
	logic wrEn;
	logic [3:0] wrAddr;
	logic [7:0] wrData;
	logic ptrWrEn;
	bfl_ptr_t ptrSel;
	logic [15:0] ptrData;
	bfl_op_t shOp;
	logic [7:0] shIn, shOut, shStatIn, shStatOut;
	modport core (output rdAddrA, rdAddrB, rdAddrC, wrEn, wrAddr, wrData,
		ptrWrEn, ptrSel, ptrData, shOp, shIn, shStatIn,
		input rdDataA, rdDataB, rdDataC, ptrX, ptrY, ptrZ, shOut, shStatOut);
	modport regs (input rdAddrA, rdAddrB, rdAddrC, wrEn, wrAddr, wrData,
		ptrWrEn, ptrSel, ptrData,
		output rdDataA, rdDataB, rdDataC, ptrX, ptrY, ptrZ);
	modport shift (input shOp, shIn, shStatIn, output shOut, shStatOut);
endinterface
`default_nettype wire

// >>> hdl/bfl_regfile.sv
// Sixteen working registers; upper six bytes double as X, Y, Z pointers.
// Reads are combinational so single-cycle operations see current values.
`default_nettype none
module bfl_regfile (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Core side
	bfl_dp_if.regs dp
);
	import bfl_pkg::*;
	typedef struct packed {
		logic [15:0][7:0] work;
	} bfl_rf_state_t;
	bfl_rf_state_t s, n;
	logic [3:0] ptrLo;
	always_comb begin
		n = s;
		ptrLo = (dp.ptrSel == PTR_X) ? IDX_XL :
			(dp.ptrSel == PTR_Y) ? IDX_YL : IDX_ZL;
		if (dp.ptrWrEn) begin
			n.work[ptrLo] = dp.ptrData[7:0];
			n.work[ptrLo + 4'h1] = dp.ptrData[15:8];
		end
		// Byte write after pointer update, so a loaded pointer byte wins
		if (dp.wrEn) begin
			n.work[dp.wrAddr] = dp.wrData;
		end
	end
	always_ff @(posedge clock) begin
		if (!resetn) s <= '0;
		else s <= n;
	end
	assign dp.rdDataA = s.work[dp.rdAddrA];
	assign dp.rdDataB = s.work[dp.rdAddrB];
	assign dp.rdDataC = s.work[dp.rdAddrC];
	assign dp.ptrX = {s.work[IDX_XL + 4'h1], s.work[IDX_XL]};
	assign dp.ptrY = {s.work[IDX_YL + 4'h1], s.work[IDX_YL]};
	assign dp.ptrZ = {s.work[IDX_ZL + 4'h1], s.work[IDX_ZL]};
endmodule
`default_nettype wire

// >>> hdl/bfl_shifter.sv
// Combinational shift and rotate unit with its status flag update.
// Holds no state; other opcodes pass the operand through, with Z, N, V and S recomputed from it.
`default_nettype none
module bfl_shifter (
	// Core side
	bfl_dp_if.shift dp
);
	import bfl_pkg::*;
	logic [7:0] res, stat;
	logic cy, neg, ovf;
	always_comb begin
		res = dp.shIn;
		stat = dp.shStatIn;
		cy = dp.shStatIn[FLAG_C];
		case (dp.shOp)
			OP_LOGIC_SHIFT_LEFT: begin
				res = {dp.shIn[6:0], 1'b0};
				cy = dp.shIn[7];
				stat[FLAG_H] = dp.shIn[3];
			end
			OP_ROTATE_LEFT_CARRY: begin
				res = {dp.shIn[6:0], dp.shStatIn[FLAG_C]};
				cy = dp.shIn[7];
			end
			OP_LOGIC_SHIFT_RIGHT: begin
				res = {1'b0, dp.shIn[7:1]};
				cy = dp.shIn[0];
			end
			OP_ROTATE_RIGHT_CARRY: begin
				res = {dp.shStatIn[FLAG_C], dp.shIn[7:1]};
				cy = dp.shIn[0];
			end
			OP_ARITH_RIGHT_SHIFT: begin
				res = {dp.shIn[7], dp.shIn[7:1]};
				cy = dp.shIn[0];
			end
			default: res = dp.shIn;
		endcase
		neg = res[7];
		ovf = neg ^ cy;
		// Flag update common to all shifts
		stat[FLAG_C] = cy;
		stat[FLAG_Z] = (res == BYTE_ZERO);
		stat[FLAG_N] = neg;
		stat[FLAG_V] = ovf;
		stat[FLAG_S] = neg ^ ovf;
		dp.shOut = res;
		dp.shStatOut = stat;
	end
endmodule
`default_nettype wire

// >>> hdl/bfl_exec_core.sv
// Execution core for shift, bit, flag, move, load and store operations.
// Assumes an asynchronous-read data memory and an I/O space that applies
// single-bit set and clear strobes itself.
`default_nettype none
module bfl_exec_core (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Command port
	input wire logic cmdValid,
	input wire bfl_pkg::bfl_op_t cmdOp,
	input wire logic [3:0] cmdDst,
	input wire logic [3:0] cmdSrc,
	input wire logic [2:0] cmdBit,
	input wire logic [7:0] cmdImm,
	input wire logic [15:0] cmdAddr,
	input wire bfl_pkg::bfl_ptr_t cmdPtr,
	input wire bfl_pkg::bfl_mode_t cmdMode,
	output logic busy,
	// Data memory
	output logic [15:0] memAddr,
	output logic [7:0] memWdata,
	output logic memRe,
	output logic memWe,
	input wire logic [7:0] memRdata,
	// I/O space bit strobes
	output logic [5:0] ioAddr,
	output logic [7:0] ioBitMask,
	output logic ioBitRaise,
	output logic ioBitLower,
	// Status register view
	output logic [7:0] statusOut,
	// Register port
	input wire logic [4:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata
);
	import bfl_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_STORE = 2'b10
	} bfl_fsm_t;

	typedef struct packed {
		bfl_fsm_t fsm;
		logic busy;
		logic [7:0] status;
		logic [3:0] dst;
		logic [15:0] memAddr;
		logic [7:0] memWdata;
		logic memRe;
		logic memWe;
		logic [5:0] ioAddr;
		logic [7:0] ioMask;
		logic ioRaise;
		logic ioLower;
		logic [7:0] regRdata;
	} bfl_core_state_t;

	bfl_core_state_t s, n;

	bfl_dp_if dp ();

	bfl_regfile u_regs (
		.clock(clock),
		.resetn(resetn),
		.dp(dp.regs)
	);

	bfl_shifter u_shift (
		.dp(dp.shift)
	);

	// One-hot mask for a bit number
	function automatic logic [7:0] bitMask(input logic [2:0] pos);
		bitMask = 8'h01 << pos;
	endfunction

	// One masked bit of a byte forced to a level
	function automatic logic [7:0] forceBit(input logic [7:0] val,
		input logic [7:0] msk, input logic lvl);
		forceBit = lvl ? (val | msk) : (val & ~msk);
	endfunction

	// Working registers sit at the bottom of the register port map
	function automatic logic isWorkReg(input logic [4:0] a);
		isWorkReg = (a <= REGA_WORK_LAST);
	endfunction

	logic take;
	logic [15:0] ptrVal;
	logic [15:0] ptrInc;
	logic [15:0] ptrDec;
	logic [7:0] mask;
	logic cmdWritesStatus;
	logic cmdWritesReg;
	logic cmdWritesPtr;

	always_comb begin
		n = s;
		// Strobes last one cycle only
		n.memRe = 1'b0;
		n.memWe = 1'b0;
		n.ioRaise = 1'b0;
		n.ioLower = 1'b0;

		dp.rdAddrA = cmdDst;
		dp.rdAddrB = cmdSrc;
		dp.rdAddrC = regAddr[3:0];
		dp.wrEn = 1'b0;
		dp.wrAddr = cmdDst;
		dp.wrData = BYTE_ZERO;
		dp.ptrWrEn = 1'b0;
		dp.ptrSel = cmdPtr;
		dp.ptrData = 16'h0000;
		dp.shOp = cmdOp;
		dp.shIn = dp.rdDataA;
		dp.shStatIn = s.status;

		// A command offered while busy is dropped, not queued
		take = cmdValid && !s.busy && (s.fsm == ST_IDLE);
		mask = bitMask(cmdBit);
		cmdWritesStatus = 1'b0;
		cmdWritesReg = 1'b0;
		cmdWritesPtr = 1'b0;

		unique case (cmdPtr)
			PTR_X: ptrVal = dp.ptrX;
			PTR_Y: ptrVal = dp.ptrY;
			PTR_Z: ptrVal = dp.ptrZ;
			default: ptrVal = dp.ptrZ;
		endcase
		// Pointers wrap within their 16 bits
		ptrInc = ptrVal + PTR_STEP;
		ptrDec = ptrVal - PTR_STEP;

		unique case (s.fsm)
			ST_IDLE: begin
				if (take) begin
					case (cmdOp)
						OP_LOGIC_SHIFT_LEFT, OP_ROTATE_LEFT_CARRY,
						OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_RIGHT_CARRY,
						OP_ARITH_RIGHT_SHIFT: begin
							// Result and flags settle in the same cycle
							dp.wrEn = 1'b1;
							dp.wrData = dp.shOut;
							n.status = dp.shStatOut;
							cmdWritesReg = 1'b1;
							cmdWritesStatus = 1'b1;
						end
						OP_NIBBLE_SWAP: begin
							dp.wrEn = 1'b1;
							dp.wrData = {dp.rdDataA[3:0], dp.rdDataA[7:4]};
							cmdWritesReg = 1'b1;
						end
						OP_REGISTER_COPY: begin
							dp.wrEn = 1'b1;
							dp.wrData = dp.rdDataB;
							cmdWritesReg = 1'b1;
						end
						OP_IMMEDIATE_LOAD: begin
							dp.wrEn = 1'b1;
							dp.wrData = cmdImm;
							cmdWritesReg = 1'b1;
						end
						OP_STATUS_BIT_RAISE: begin
							n.status = forceBit(s.status, mask, 1'b1);
							cmdWritesStatus = 1'b1;
						end
						OP_STATUS_BIT_LOWER: begin
							n.status = forceBit(s.status, mask, 1'b0);
							cmdWritesStatus = 1'b1;
						end
						OP_IO_BIT_RAISE: begin
							// The I/O side owns the read-modify-write
							n.ioAddr = cmdAddr[5:0];
							n.ioMask = mask;
							n.ioRaise = 1'b1;
						end
						OP_IO_BIT_LOWER: begin
							n.ioAddr = cmdAddr[5:0];
							n.ioMask = mask;
							n.ioLower = 1'b1;
						end
						OP_REG_BIT_TO_TFLAG: begin
							n.status[FLAG_T] = |(dp.rdDataB & mask);
							cmdWritesStatus = 1'b1;
						end
						OP_TFLAG_TO_REG_BIT: begin
							dp.wrEn = 1'b1;
							dp.wrData = forceBit(dp.rdDataA, mask,
								s.status[FLAG_T]);
							cmdWritesReg = 1'b1;
						end
						OP_MEMORY_READ_INDIRECT: begin
							n.fsm = ST_LOAD;
							n.busy = 1'b1;
							n.dst = cmdDst;
							n.memRe = 1'b1;
							unique case (cmdMode)
								AM_PRE_DEC: begin
									n.memAddr = ptrDec;
									dp.ptrWrEn = 1'b1;
									cmdWritesPtr = 1'b1;
									dp.ptrData = ptrDec;
								end
								AM_POST_INC: begin
									n.memAddr = ptrVal;
									dp.ptrWrEn = 1'b1;
									cmdWritesPtr = 1'b1;
									dp.ptrData = ptrInc;
								end
								default: n.memAddr = ptrVal;
							endcase
						end
						OP_MEMORY_READ_DIRECT: begin
							n.fsm = ST_LOAD;
							n.busy = 1'b1;
							n.dst = cmdDst;
							n.memRe = 1'b1;
							n.memAddr = cmdAddr;
						end
						OP_MEMORY_WRITE_INDIRECT: begin
							n.fsm = ST_STORE;
							n.busy = 1'b1;
							n.memWe = 1'b1;
							n.memWdata = dp.rdDataB;
							unique case (cmdMode)
								AM_PRE_DEC: begin
									n.memAddr = ptrDec;
									dp.ptrWrEn = 1'b1;
									cmdWritesPtr = 1'b1;
									dp.ptrData = ptrDec;
								end
								AM_POST_INC: begin
									n.memAddr = ptrVal;
									dp.ptrWrEn = 1'b1;
									cmdWritesPtr = 1'b1;
									dp.ptrData = ptrInc;
								end
								default: n.memAddr = ptrVal;
							endcase
						end
						default: begin
							n.fsm = ST_IDLE;
						end
					endcase
				end
			end
			ST_LOAD: begin
				// Memory answers in the strobe cycle, second cycle of the load
				dp.wrEn = 1'b1;
				dp.wrAddr = s.dst;
				dp.wrData = memRdata;
				cmdWritesReg = 1'b1;
				n.fsm = ST_IDLE;
				n.busy = 1'b0;
			end
			ST_STORE: begin
				// Memory takes the byte at the edge closing this cycle
				n.fsm = ST_IDLE;
				n.busy = 1'b0;
			end
			default: begin
				n.fsm = ST_IDLE;
				n.busy = 1'b0;
			end
		endcase

		// Software writes lose to a same-cycle execution write,
		// pointer steps included
		if (regWr && !cmdWritesReg && !cmdWritesPtr &&
			isWorkReg(regAddr)) begin
			dp.wrEn = 1'b1;
			dp.wrAddr = regAddr[3:0];
			dp.wrData = regWdata;
		end
		if (regWr && !cmdWritesStatus && (regAddr == REGA_STATUS)) begin
			n.status = regWdata;
		end

		// Read data stand for exactly one cycle after the strobe
		n.regRdata = BYTE_ZERO;
		if (regRd) begin
			if (isWorkReg(regAddr)) n.regRdata = dp.rdDataC;
			else if (regAddr == REGA_STATUS) n.regRdata = s.status;
			else if (regAddr == REGA_BUSY) n.regRdata = {7'h00, s.busy};
			else n.regRdata = BYTE_ZERO;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			s.fsm <= ST_IDLE;
			s.busy <= 1'b0;
			s.status <= STATUS_RST;
			s.dst <= 4'h0;
			s.memAddr <= 16'h0000;
			s.memWdata <= BYTE_ZERO;
			s.memRe <= 1'b0;
			s.memWe <= 1'b0;
			s.ioAddr <= 6'h00;
			s.ioMask <= BYTE_ZERO;
			s.ioRaise <= 1'b0;
			s.ioLower <= 1'b0;
			s.regRdata <= BYTE_ZERO;
		end else begin
			s <= n;
		end
	end

	assign busy = s.busy;
	assign memAddr = s.memAddr;
	assign memWdata = s.memWdata;
	assign memRe = s.memRe;
	assign memWe = s.memWe;
	assign ioAddr = s.ioAddr;
	assign ioBitMask = s.ioMask;
	assign ioBitRaise = s.ioRaise;
	assign ioBitLower = s.ioLower;
	assign statusOut = s.status;
	assign regRdata = s.regRdata;
endmodule
`default_nettype wire

// >>> dv/bfl_exec_core_props.sv
// Checker on the core's command timing, strobes and status effects.
// Bound to bfl_exec_core; one clock, synchronous reset.
`default_nettype none
module bfl_exec_core_props (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Command port
	input wire logic cmdValid,
	input wire bfl_pkg::bfl_op_t cmdOp,
	input wire logic [2:0] cmdBit,
	input wire logic [15:0] cmdAddr,
	input wire logic busy,
	// Memory, I/O and status
	input wire logic [15:0] memAddr,
	input wire logic memRe,
	input wire logic memWe,
	input wire logic [7:0] ioBitMask,
	input wire logic ioBitRaise,
	input wire logic ioBitLower,
	input wire logic [7:0] statusOut
);
	timeunit 1ns;
	timeprecision 1ps;
	import bfl_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence taken(bfl_op_t o);
		cmdValid && !busy && cmdOp == o;
	endsequence
	// Second cycle of a memory access, flags untouched in its strobe cycle
	sequence rdStep;
		memRe && busy && $stable(statusOut) ##1 !busy && !memRe;
	endsequence
	sequence wrStep;
		memWe && busy && $stable(statusOut) ##1 !busy && !memWe;
	endsequence
	flag_raise_a:
	assert property (taken(OP_STATUS_BIT_RAISE) |=>
		statusOut == ($past(statusOut) | (8'h01 << $past(cmdBit))))
		else $error("flag raise wrong");
	flag_lower_a:
	assert property (taken(OP_STATUS_BIT_LOWER) |=>
		statusOut == ($past(statusOut) & ~(8'h01 << $past(cmdBit))))
		else $error("flag lower wrong");
	load_start_a:
	assert property (taken(OP_MEMORY_READ_INDIRECT) |=> rdStep)
		else $error("indirect load timing wrong");
	direct_load_a:
	assert property (taken(OP_MEMORY_READ_DIRECT) |=>
		(memAddr == $past(cmdAddr)) ##0 rdStep)
		else $error("direct load wrong");
	store_start_a:
	assert property (taken(OP_MEMORY_WRITE_INDIRECT) |=> wrStep)
		else $error("store timing wrong");
	io_raise_a:
	assert property (taken(OP_IO_BIT_RAISE) |=> ioBitRaise && !ioBitLower
		&& ioBitMask == (8'h01 << $past(cmdBit)) && $stable(statusOut)
		##1 !ioBitRaise) else $error("io raise wrong");
	io_lower_a:
	assert property (taken(OP_IO_BIT_LOWER) |=> ioBitLower && !ioBitRaise
		&& ioBitMask == (8'h01 << $past(cmdBit)) && $stable(statusOut)
		##1 !ioBitLower) else $error("io lower wrong");
	busy_once_a:
	assert property (busy |=> !busy) else $error("busy too long");
endmodule
`default_nettype wire

// >>> dv/bfl_mem_model.sv
// Data memory and I/O space facing the execution core.
// Reads are asynchronous; I/O bits change on the core's strobes.
`default_nettype none
module bfl_mem_model (
	// Clock
	input wire logic clock,
	// Data memory
	input wire logic [15:0] memAddr,
	input wire logic [7:0] memWdata,
	input wire logic memRe,
	input wire logic memWe,
	output logic [7:0] memRdata,
	// I/O bit strobes
	input wire logic [5:0] ioAddr,
	input wire logic [7:0] ioBitMask,
	input wire logic ioBitRaise,
	input wire logic ioBitLower
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:255];
	logic [7:0] io [0:63];
	logic [7:0] lastRd = 8'h00;
	// Off-strobe data inverts, so a late sample never matches
	assign memRdata = memRe ? mem[memAddr[7:0]] : ~lastRd;
	always @(posedge clock) begin
		if (memRe)
			lastRd <= mem[memAddr[7:0]];
		if (memWe)
			mem[memAddr[7:0]] <= memWdata;
		if (ioBitRaise)
			io[ioAddr] <= io[ioAddr] | ioBitMask;
		if (ioBitLower)
			io[ioAddr] <= io[ioAddr] & ~ioBitMask;
	end
endmodule
`default_nettype wire

// >>> dv/test_bit_flag_load_store_exec.sv
// Self-checking bench: core, memory model and bound checker.
// Commands and register accesses follow the core's hand-over timing.
`default_nettype none
module test_bit_flag_load_store_exec;
	timeunit 1ns;
	timeprecision 1ps;
	import bfl_pkg::*;
	logic clock = 1'h0, resetn = 1'h0, cmdValid = 1'h0;
	logic regWr = 1'h0, regRd = 1'h0;
	logic busy, memRe, memWe, ioBitRaise, ioBitLower;
	bfl_op_t cmdOp = OP_NONE;
	bfl_ptr_t cmdPtr = PTR_X;
	bfl_mode_t cmdMode = AM_PLAIN;
	logic [3:0] cmdDst = 4'h0, cmdSrc = 4'h0;
	logic [2:0] cmdBit = 3'h0;
	logic [7:0] cmdImm = 8'h00, regWdata = 8'h00;
	logic [15:0] cmdAddr = 16'h0000;
	logic [4:0] regAddr = 5'h00;
	logic [7:0] memRdata, memWdata, ioBitMask, statusOut, regRdata;
	logic [15:0] memAddr, ptr, np;
	logic [5:0] ioAddr;
	logic [8:0] ex;
	logic [7:0] v, m, d;
	logic [4:0] pa;
	int mismatches = 0;
	int n_compared = 0;
	bfl_op_t shOps [5] = '{OP_LOGIC_SHIFT_LEFT, OP_ROTATE_LEFT_CARRY,
		OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT};
	bfl_exec_core dut_u (.*);
	bfl_mem_model mem_u (.*);
	always #5 clock = ~clock;
	// Carry out on top, result below
	function automatic logic [8:0] shx(bfl_op_t o, logic [7:0] x, logic c);
		case (o)
			OP_LOGIC_SHIFT_LEFT: return {x, 1'h0};
			OP_ROTATE_LEFT_CARRY: return {x, c};
			OP_LOGIC_SHIFT_RIGHT: return {x[0], 1'h0, x[7:1]};
			OP_ROTATE_RIGHT_CARRY: return {x[0], c, x[7:1]};
			default: return {x[0], x[7], x[7:1]};
		endcase
	endfunction
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] x);
		@(posedge clock);
		regAddr <= a;
		regWdata <= x;
		regWr <= 1'h1;
		@(posedge clock);
		regWr <= 1'h0;
	endtask
	task automatic rchk(input logic [4:0] a, input logic [7:0] e);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge clock);
		regRd <= 1'h0;
		#1 chk($sformatf("reg %h", a), e, regRdata);
	endtask
	// Returns in the cycle after the command was taken
	task automatic cmd(input bfl_op_t o, input logic [3:0] dd, s,
		input logic [2:0] b, input logic [15:0] a,
		input bfl_ptr_t p = PTR_X, input bfl_mode_t md = AM_PLAIN);
		@(posedge clock);
		cmdOp <= o;
		cmdDst <= dd;
		cmdSrc <= s;
		cmdBit <= b;
		cmdAddr <= a;
		cmdImm <= a[7:0];
		cmdPtr <= p;
		cmdMode <= md;
		cmdValid <= 1'h1;
		@(posedge clock);
		cmdValid <= 1'h0;
		#1;
	endtask
	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		conclude();
	end
	initial begin
		for (int i = 0; i < 256; i++)
			mem_u.mem[i] = 8'(i) ^ 8'h5A;
		for (int i = 0; i < 64; i++)
			mem_u.io[i] = 8'h00;
		repeat (3) @(posedge clock);
		resetn <= 1'h1;
		rchk(REGA_STATUS, STATUS_RST);
		rchk(REGA_BUSY, 8'h00);
		rchk(5'h12, 8'h00);
		$display("test reset done");
		foreach (shOps[i]) for (int j = 0; j < 2; j++) begin
			v = j ? 8'h01 : 8'h81;
			ex = shx(shOps[i], v, j[0]);
			wr(REGA_STATUS, {7'h00, j[0]});
			cmd(OP_IMMEDIATE_LOAD, 4'h1, 4'h0, 3'h0, {8'h00, v});
			chk("load flags", {7'h00, j[0]}, statusOut);
			cmd(shOps[i], 4'h1, 4'h0, 3'h0, 16'h0000);
			chk("carry", ex[8], statusOut[FLAG_C]);
			chk("zero", ex[7:0] == 8'h00, statusOut[FLAG_Z]);
			chk("negative", ex[7], statusOut[FLAG_N]);
			chk("overflow", ex[8] ^ ex[7], statusOut[FLAG_V]);
			rchk(5'h01, ex[7:0]);
		end
		$display("test shifts done");
		for (int b = 0; b < 8; b++) begin
			m = 8'h01 << b;
			wr(REGA_STATUS, 8'h00);
			cmd(OP_STATUS_BIT_RAISE, 4'h0, 4'h0, 3'(b), 16'h0000);
			chk("raise", m, statusOut);
			m = ~m;
			wr(REGA_STATUS, 8'hFF);
			cmd(OP_STATUS_BIT_LOWER, 4'h0, 4'h0, 3'(b), 16'h0000);
			chk("lower", m, statusOut);
		end
		$display("test flags done");
		cmd(OP_IMMEDIATE_LOAD, 4'h2, 4'h0, 3'h0, 16'h0008);
		wr(REGA_STATUS, 8'h40);
		cmd(OP_REG_BIT_TO_TFLAG, 4'h0, 4'h2, 3'h2, 16'h0000);
		chk("T clear", 8'h00, statusOut);
		cmd(OP_REG_BIT_TO_TFLAG, 4'h0, 4'h2, 3'h3, 16'h0000);
		chk("T set", 8'h40, statusOut);
		cmd(OP_TFLAG_TO_REG_BIT, 4'h2, 4'h0, 3'h5, 16'h0000);
		cmd(OP_REGISTER_COPY, 4'h3, 4'h2, 3'h0, 16'h0000);
		cmd(OP_NIBBLE_SWAP, 4'h3, 4'h0, 3'h0, 16'h0000);
		rchk(5'h02, 8'h28);
		rchk(5'h03, 8'h82);
		@(posedge clock);
		#1 chk("read idle", 8'h00, regRdata);
		chk("move flags", 8'h40, statusOut);
		$display("test bits done");
		cmd(OP_IO_BIT_RAISE, 4'h0, 4'h0, 3'h2, 16'h0025);
		chk("io raise", 1'h1, ioBitRaise);
		chk("io addr", 16'h0025, ioAddr);
		cmd(OP_IO_BIT_RAISE, 4'h0, 4'h0, 3'h7, 16'h0025);
		cmd(OP_IO_BIT_LOWER, 4'h0, 4'h0, 3'h2, 16'h0025);
		chk("io lower", 1'h1, ioBitLower);
		@(posedge clock);
		#1 chk("io reg", 8'h80, mem_u.io[6'h25]);
		$display("test io done");
		wr(REGA_STATUS, 8'h55);
		for (int s = 0; s < 2; s++) for (int p = 0; p < 3; p++)
		for (int k = 0; k < 3; k++) begin
			ptr = k == 2 ? 16'h0100 : 16'h00FF;
			np = k == 1 ? 16'h0100 : 16'h00FF;
			pa = 5'(IDX_XL) + 5'(2 * p);
			d = 8'h30 + 8'(p * 3 + k);
			wr(pa, ptr[7:0]);
			wr(pa + 5'h01, ptr[15:8]);
			cmd(OP_IMMEDIATE_LOAD, 4'h9, 4'h0, 3'h0, {8'h00, d});
			cmd(s ? OP_MEMORY_WRITE_INDIRECT : OP_MEMORY_READ_INDIRECT,
				4'(p * 3 + k), 4'h9, 3'h0, 16'h0000, bfl_ptr_t'(p),
				bfl_mode_t'(k));
			chk("mem addr", 16'h00FF, memAddr);
			if (s) begin
				chk("store data", d, memWdata);
				@(posedge clock);
				#1 chk("mem", d, mem_u.mem[8'hFF]);
			end else
				rchk(5'(p * 3 + k), 8'hFF ^ 8'h5A);
			rchk(pa, np[7:0]);
			rchk(pa + 5'h01, np[15:8]);
		end
		cmd(OP_MEMORY_READ_DIRECT, 4'h7, 4'h0, 3'h0, 16'h0042);
		rchk(5'h07, 8'h42 ^ 8'h5A);
		chk("mem flags", 8'h55, statusOut);
		$display("test memory done");
		conclude();
	end
endmodule
bind bfl_exec_core bfl_exec_core_props props_u (.*);
`default_nettype wire
